// *** uhic_pkg.sv ***
/*
 * Package of the hub microcontroller interrupt controller: register
 * offsets, field layouts, vectors, timing counts and carrier types.
 * Assumes a 125 MHz pclk and an APB master for software access.
 */
// Summary of operation
// - Endpoint enable bits 0-2 gate A endpoints 0-2, bits 3-4 B 0-1.
// - Only presetn clears global and endpoint enable registers; bus reset does not.
// - One pending flip-flop per source, set by event, cleared by service.
// - Pending flag requests service only while its enable bit is set; DAC has none and always requests.
// - Highest-priority request is serviced after current instruction ends.
// - Service clears global enable, then pending flag, then calls vector.
// - Forced call pushes program counter plus carry and zero flags.
// - Return-from-interrupt restores PC and flags and sets global enable.
// - Disable/enable instructions touch only global enable; nesting allowed.
// - Request-pending status bit 7 shows pending requests while disabled.
// - Priority follows vector number: 1 highest, 12 lowest.
// - Reset at 0x0000; vectors 1-12 at 0x0002 to 0x0018, step two.
// - Entry latency: remaining instruction, ten call cycles, five jump.
// - Bus reset detected on SE0: maybe after 12 us, always after 16 us.
// - Bus reset sets status bit 5 and clears address and hub registers.
// - Bus reset event raised when SE0 ends; aborts power-on delay.
// - Endpoint event on final acknowledge; none if IN is unacknowledged.
// - Hub event on connect change, gated babble/resume; forced ports give no connect-change event.
// - GPIO shares one vector; one triggering pin blocks others.
// - Acknowledge leaves GPIO port enables unchanged.
// - Global enable bits: 0 reset,1 128us,2 1ms,3 hub,5 GPIO,6 I2C.
package uhic_pkg;
  localparam int UHIC_NSRC = 12;
  // Register byte addresses
  localparam logic [7:0] UHIC_A_GLOBAL_EN = 8'h00;
  localparam logic [7:0] UHIC_A_EP_EN = 8'h04;
  localparam logic [7:0] UHIC_A_PENDING = 8'h08;
  localparam logic [7:0] UHIC_A_STATUS = 8'h0c;
  localparam logic [7:0] UHIC_A_GPIO_PEN = 8'h10;
  // Field masks and positions
  localparam logic [7:0] UHIC_GEN_MASK = 8'h6f;
  localparam logic [7:0] UHIC_EPEN_MASK = 8'h1f;
  localparam int UHIC_ST_GIE = 2;
  localparam int UHIC_ST_BUSRST = 5;
  localparam int UHIC_ST_IRQP = 7;
  localparam logic [7:0] UHIC_RST8 = 8'h00;
  // Source index (vector number minus one)
  localparam int UHIC_S_BUSRST = 0;
  localparam int UHIC_S_T128 = 1;
  localparam int UHIC_S_T1MS = 2;
  localparam int UHIC_S_ADDR_A_ENDPOINT0 = 3;
  localparam int UHIC_S_HUB = 8;
  localparam int UHIC_S_DAC = 9;
  localparam int UHIC_S_GPIO = 10;
  localparam int UHIC_S_I2C = 11;
  localparam int UHIC_G_HUB = 3;
  localparam int UHIC_G_GPIO = 5;
  localparam int UHIC_G_I2C = 6;
  localparam logic [13:0] UHIC_RESET_VEC = 14'h0000;
  localparam logic [13:0] UHIC_VEC_BASE = 14'h0002;
  // Timing
  localparam int UHIC_CLK_MHZ = 125;
  localparam int UHIC_CALL_CYC = 10;
  localparam int UHIC_JMP_CYC = 5;
  localparam int UHIC_SE0_MIN_US = 12;
  localparam int UHIC_SE0_MAX_US = 16;
  // SE0 threshold: 14 us sits inside the 12..16 us window
  localparam int UHIC_SE0_CYC = (UHIC_SE0_MIN_US + UHIC_SE0_MAX_US)
                                 * UHIC_CLK_MHZ / 2;
  localparam int UHIC_SE0_W = 11;
  // Core handshake
  typedef struct packed {
    logic instr_done;
    logic di;
    logic ei;
    logic return_from_irq_instruction;
  } uhic_core_s;
  typedef struct packed {
    logic [13:0] pc;
    logic carry_flag;
    logic zero_flag;
  } uhic_frame_s;
  typedef enum logic [3:0] {
    UHIC_IDLE = 4'b0001,
    UHIC_CALL = 4'b0010,
    UHIC_JUMP = 4'b0100,
    UHIC_DONE = 4'b1000
  } uhic_state_e;
endpackage

// *** uhic_stack.sv ***
/*
 * Small stack memory that holds return frames of forced calls.
 * Assumes push and pop are never requested in the same cycle.
 */
`timescale 1ns/1ps
module uhic_stack #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Access
  input wire logic push,
  input wire logic pop,
  input wire uhic_pkg::uhic_frame_s wdata,
  output uhic_pkg::uhic_frame_s rdata,
  output logic [AW:0] level
);
  import uhic_pkg::*;
  uhic_frame_s mem [DEPTH];
  logic [AW-1:0] top;

  // Frame storage
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[level[AW-1:0]] <= wdata;
    end
  end

  // Registered read of the top frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (pop) begin
      rdata <= mem[top];
    end
  end

  assign top = level[AW-1:0] - 1'b1;

  // Fill level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= '0;
    end else if (push && level != (AW+1)'(DEPTH)) begin
      level <= level + 1'b1;
    end else if (pop && level != '0) begin
      level <= level - 1'b1;
    end
  end
endmodule

// *** uhic_top.sv ***
/*
 * Interrupt controller of a USB hub microcontroller: pending flags,
 * enable registers, priority pick, forced call sequence and return.
 * Assumes the core pulses instr_done at instruction ends, an APB master,
 * and event pulses from the SIE, hub, timers, GPIO and I2C logic.
 */
`timescale 1ns/1ps
module uhic_top #(
  parameter int STACK_DEPTH = 16,
  parameter int SE0_CYC = uhic_pkg::UHIC_SE0_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Upstream line levels (pins)
  input wire logic up_dp,
  input wire logic up_dm,
  // Source events from same-clock logic: one-cycle pulses, except gpio_trig and the nak, port enable and forced masks, which are levels
  input wire logic tick_128us,
  input wire logic tick_1ms,
  input wire logic [4:0] ep_ack,
  input wire logic [4:0] ep_in_nak,
  input wire logic [6:0] hub_conn_chg,
  input wire logic [6:0] hub_babble,
  input wire logic [6:0] hub_resume,
  input wire logic [6:0] hub_port_en,
  input wire logic [6:0] hub_forced,
  input wire logic dac_event,
  input wire logic [7:0] gpio_trig,
  input wire logic i2c_event,
  // Processor core
  input wire uhic_pkg::uhic_core_s core,
  input wire uhic_pkg::uhic_frame_s core_state,
  output logic core_hold,
  output logic force_call,
  output logic [13:0] call_vector,
  output logic restore_valid,
  output uhic_pkg::uhic_frame_s restore_frame,
  output logic global_en,
  // Side effects of bus reset
  output logic usb_clear_regs,
  output logic abort_por_delay
);
  import uhic_pkg::*;

  logic [7:0] gen_reg;
  logic [7:0] ep_reg;
  logic [UHIC_NSRC-1:0] pending;
  logic [UHIC_NSRC-1:0] enabled;
  logic [UHIC_NSRC-1:0] req;
  logic [UHIC_NSRC-1:0] event_in;
  logic [UHIC_NSRC-1:0] clr_vec;
  logic [7:0] gpio_port_en;
  logic [7:0] gpio_latched;
  logic bus_rst_flag;
  logic [3:0] sel_idx;
  logic any_req;
  uhic_state_e state;
  logic [3:0] cnt;
  logic [3:0] svc_idx;
  logic [2:0] dp_sync;
  logic [2:0] dm_sync;
  logic se0;
  logic [UHIC_SE0_W-1:0] se0_cnt;
  logic in_reset;
  logic rst_end;
  logic apb_wr;
  logic apb_rd;
  logic push;
  uhic_frame_s stk_rdata;
  logic [$clog2(STACK_DEPTH):0] stk_level;
  logic pop_d;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // Upstream pins pass three flops; level is taken once 2nd and 3rd agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_sync <= 3'h7;
      dm_sync <= 3'h0;
      se0 <= 1'b0;
    end else begin
      dp_sync <= {dp_sync[1:0], up_dp};
      dm_sync <= {dm_sync[1:0], up_dm};
      if (dp_sync[2] == dp_sync[1] && dm_sync[2] == dm_sync[1]) begin
        se0 <= !dp_sync[2] && !dm_sync[2];
      end
    end
  end

  // SE0 duration count and bus reset detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      se0_cnt <= '0;
      in_reset <= 1'b0;
      rst_end <= 1'b0;
    end else begin
      rst_end <= 1'b0;
      if (!se0) begin
        se0_cnt <= '0;
        rst_end <= in_reset;
        in_reset <= 1'b0;
      end else if (se0_cnt == UHIC_SE0_W'(SE0_CYC - 1)) begin
        in_reset <= 1'b1;
      end else begin
        se0_cnt <= se0_cnt + 1'b1;
      end
    end
  end

  // Bus reset side effects, one pulse at detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_clear_regs <= 1'b0;
      abort_por_delay <= 1'b0;
    end else begin
      usb_clear_regs <= se0 && se0_cnt == UHIC_SE0_W'(SE0_CYC - 1)
                        && !in_reset;
      abort_por_delay <= se0 && se0_cnt == UHIC_SE0_W'(SE0_CYC - 1)
                         && !in_reset;
    end
  end

  // Status bit 5 records the bus reset; software write of 1 clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rst_flag <= 1'b0;
    end else if (se0 && se0_cnt == UHIC_SE0_W'(SE0_CYC - 1)) begin
      bus_rst_flag <= 1'b1;
    end else if (apb_wr && paddr == UHIC_A_STATUS
                 && pwdata[UHIC_ST_BUSRST]) begin
      bus_rst_flag <= 1'b0;
    end
  end

  // GPIO: first triggering pin blocks others until it releases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_latched <= '0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!gpio_trig[i] || !gpio_port_en[i]) begin
          gpio_latched[i] <= 1'b0;
        end
      end
      if (gpio_latched == '0 && (gpio_trig & gpio_port_en) != '0) begin
        gpio_latched <= gpio_trig & gpio_port_en & -(gpio_trig & gpio_port_en);
      end
    end
  end

  // Event map by source index; endpoint events only on final ack
  always_comb begin
    event_in = '0;
    event_in[UHIC_S_BUSRST] = rst_end;
    event_in[UHIC_S_T128] = tick_128us;
    event_in[UHIC_S_T1MS] = tick_1ms;
    event_in[UHIC_S_ADDR_A_ENDPOINT0 +: 5] = ep_ack & ~ep_in_nak;
    event_in[UHIC_S_HUB] = |((hub_conn_chg & ~hub_forced)
                           | ((hub_babble | hub_resume) & hub_port_en));
    event_in[UHIC_S_DAC] = dac_event;
    event_in[UHIC_S_GPIO] = gpio_latched == '0
                            && (gpio_trig & gpio_port_en) != '0;
    event_in[UHIC_S_I2C] = i2c_event;
  end

  // Pending flags: set wins over service clear; repeats collapse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= '0;
    end else begin
      pending <= (pending & ~clr_vec) | event_in;
    end
  end

  // Enable map: global and endpoint registers per source, DAC always enabled
  always_comb begin
    enabled = '0;
    enabled[UHIC_S_BUSRST +: 3] = gen_reg[2:0];
    enabled[UHIC_S_ADDR_A_ENDPOINT0 +: 5] = ep_reg[4:0];
    enabled[UHIC_S_HUB] = gen_reg[UHIC_G_HUB];
    enabled[UHIC_S_DAC] = 1'b1;
    enabled[UHIC_S_GPIO] = gen_reg[UHIC_G_GPIO];
    enabled[UHIC_S_I2C] = gen_reg[UHIC_G_I2C];
  end

  assign req = pending & enabled;

  // Fixed priority, lowest index wins
  always_comb begin
    sel_idx = '0;
    any_req = |req;
    for (int i = UHIC_NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        sel_idx = 4'(i);
      end
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_reg <= UHIC_RST8;
      ep_reg <= UHIC_RST8;
      gpio_port_en <= UHIC_RST8;
    end else if (apb_wr) begin
      unique case (paddr)
        UHIC_A_GLOBAL_EN: gen_reg <= pwdata[7:0] & UHIC_GEN_MASK;
        UHIC_A_EP_EN: ep_reg <= pwdata[7:0] & UHIC_EPEN_MASK;
        UHIC_A_GPIO_PEN: gpio_port_en <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Acknowledge sequencer: wait instruction end, call, jump slot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= UHIC_IDLE;
      cnt <= '0;
      svc_idx <= '0;
      clr_vec <= '0;
      force_call <= 1'b0;
      call_vector <= UHIC_RESET_VEC;
      core_hold <= 1'b0;
    end else begin
      clr_vec <= '0;
      force_call <= 1'b0;
      unique case (state)
        UHIC_IDLE: begin
          if (core.instr_done && any_req && global_en) begin
            svc_idx <= sel_idx;
            clr_vec[sel_idx] <= 1'b1;
            call_vector <= UHIC_VEC_BASE + {9'h000, sel_idx, 1'b0};
            core_hold <= 1'b1;
            cnt <= 4'(UHIC_CALL_CYC - 1);
            state <= UHIC_CALL;
          end
        end
        UHIC_CALL: begin
          if (cnt == '0) begin
            force_call <= 1'b1;
            cnt <= 4'(UHIC_JMP_CYC - 1);
            state <= UHIC_JUMP;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        UHIC_JUMP: begin
          if (cnt == '0) begin
            state <= UHIC_DONE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        UHIC_DONE: begin
          core_hold <= 1'b0;
          state <= UHIC_IDLE;
        end
      endcase
    end
  end

  assign push = state == UHIC_IDLE && core.instr_done && any_req && global_en;

  // Global enable: cleared on acknowledge, set by return or enable instr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_en <= 1'b0;
    end else if (push) begin
      global_en <= 1'b0;
    end else if (core.return_from_irq_instruction || core.ei) begin
      global_en <= 1'b1;
    end else if (core.di) begin
      global_en <= 1'b0;
    end
  end

  // Return frame stack: push on call, pop on return
  uhic_stack #(
    .DEPTH(STACK_DEPTH),
    .AW($clog2(STACK_DEPTH))
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .push(push),
    .pop(core.return_from_irq_instruction && !push),
    .wdata(core_state),
    .rdata(stk_rdata),
    .level(stk_level)
  );

  // Restore frame handed back two cycles after the pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pop_d <= 1'b0;
      restore_valid <= 1'b0;
      restore_frame <= '0;
    end else begin
      pop_d <= core.return_from_irq_instruction && !push;
      restore_valid <= pop_d;
      if (pop_d) begin
        restore_frame <= stk_rdata;
      end
    end
  end

  // APB: zero wait states, unmapped reads zero with error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        pslverr <= !(paddr inside {UHIC_A_GLOBAL_EN, UHIC_A_EP_EN,
          UHIC_A_PENDING, UHIC_A_STATUS, UHIC_A_GPIO_PEN});
      end
      if (apb_rd) begin
        prdata <= '0;
        unique case (paddr)
          UHIC_A_GLOBAL_EN: prdata[7:0] <= gen_reg;
          UHIC_A_EP_EN: prdata[7:0] <= ep_reg;
          UHIC_A_PENDING: prdata[UHIC_NSRC-1:0] <= pending;
          UHIC_A_STATUS: begin
            prdata[UHIC_ST_GIE] <= global_en;
            prdata[UHIC_ST_BUSRST] <= bus_rst_flag;
            prdata[UHIC_ST_IRQP] <= |req;
          end
          UHIC_A_GPIO_PEN: prdata[7:0] <= gpio_port_en;
          default: ;
        endcase
      end
    end
  end

  // Checks
  sequence s_ack;
    state == UHIC_IDLE && core.instr_done && any_req && global_en;
  endsequence

  AST_GIE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |=> !global_en) else $error("gie not cleared");
  AST_CALL_TIME: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |-> ##11 force_call) else $error("call late");
  AST_NO_REQ_GIE: assert property (@(posedge pclk) disable iff (!presetn)
    !global_en && state == UHIC_IDLE |=> state == UHIC_IDLE)
    else $error("ack while disabled");
  AST_PEND_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |-> ##2 !pending[svc_idx] || $past(event_in[svc_idx]))
    else $error("flag not cleared");
  AST_PRIO: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |-> (req & ((12'h001 << sel_idx) - 12'h001)) == '0)
    else $error("priority");
  AST_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |-> enabled[sel_idx]) else $error("masked serviced");
  AST_VEC: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack |=> call_vector == UHIC_VEC_BASE + {9'h000, svc_idx, 1'b0})
    else $error("vector");
  AST_RETURN_FROM_IRQ_INSTRUCTION: assert property (@(posedge pclk) disable iff (!presetn)
    core.return_from_irq_instruction && !push |=> global_en) else $error("return_from_irq_instruction gie");
  AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    force_call |-> core_hold) else $error("hold");
  // Nesting is limited by stack room; a push must find a free slot
  AST_STACK_ROOM: assert property (@(posedge pclk)
    disable iff (!presetn) push |-> stk_level < STACK_DEPTH)
    else $error("stack full at acknowledge");
endmodule

// *** uhic_core_model.sv ***
/*
 * Behavioural processor core facing the interrupt controller.
 * Assumes one pclk domain and bench requests as one-cycle pulses.
 */
`timescale 1ns/1ps
module uhic_core_model #(
  parameter int INSTR_LEN = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench requests: ei, di, return_from_irq_instruction
  input wire logic [2:0] req,
  // Controller side
  input wire logic core_hold,
  input wire logic force_call,
  input wire logic [13:0] call_vector,
  input wire logic restore_valid,
  input wire uhic_pkg::uhic_frame_s restore_frame,
  output uhic_pkg::uhic_core_s core,
  output uhic_pkg::uhic_frame_s core_state
);
  import uhic_pkg::*;
  int cnt;
  logic [2:0] want;
  logic issue;
  // Last cycle of an instruction; none completes while held
  assign issue = !core_hold && cnt == INSTR_LEN - 1;
  // Requests wait for the end of the running instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      want <= 3'h0;
    end else begin
      want <= (issue ? 3'h0 : want) | req;
    end
  end
  // Sequencing; state stays frozen under hold so the push sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      core <= '0;
      core_state <= '0;
    end else begin
      core <= '0;
      if (issue) begin
        core.instr_done <= 1'b1;
        {core.ei, core.di, core.return_from_irq_instruction} <= want;
      end
      if (force_call) begin
        core_state.pc <= call_vector;
      end else if (restore_valid) begin
        core_state <= restore_frame;
      end else if (!core_hold) begin
        cnt <= issue ? 0 : cnt + 1;
        if (cnt == INSTR_LEN - 2) begin
          core_state.pc <= core_state.pc + 14'h0001;
          core_state.carry_flag <= ~core_state.carry_flag;
          core_state.zero_flag <= core_state.pc[0];
        end
      end
    end
  end
endmodule

// *** tb_top.sv ***
/*
 * Self-checking bench of the interrupt controller: APB tasks, event
 * pulses, a core model and a watchdog.
 * Assumes the design package and the core model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
  import uhic_pkg::*;
  localparam int SE0_SMALL = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, gpio_trig;
  logic [31:0] pwdata, prdata;
  logic up_dp, up_dm, core_hold, force_call, restore_valid, global_en;
  logic usb_clear_regs, abort_por_delay;
  logic [29:0] evt;
  logic [4:0] ep_in_nak;
  logic [6:0] hub_port_en, hub_forced;
  logic [2:0] creq;
  logic [13:0] call_vector;
  logic [11:0] exp_pend;
  uhic_core_s core;
  uhic_frame_s core_state, restore_frame, snap;
  int error_cnt = 0;
  int samples_checked = 0;
  int calls = 0;
  int clears = 0;
  int aborts = 0;
  int order[8] = '{1, 2, 3, 7, 8, 9, 10, 11};
  // Event bits: ticks, endpoint acks, dac, i2c, hub connect/babble/resume
  uhic_top #(.SE0_CYC(SE0_SMALL)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .up_dp(up_dp), .up_dm(up_dm),
    .tick_128us(evt[0]), .tick_1ms(evt[1]), .ep_ack(evt[6:2]),
    .ep_in_nak(ep_in_nak), .hub_conn_chg(evt[15:9]),
    .hub_babble(evt[22:16]), .hub_resume(evt[29:23]),
    .hub_port_en(hub_port_en), .hub_forced(hub_forced),
    .dac_event(evt[7]), .gpio_trig(gpio_trig), .i2c_event(evt[8]),
    .core(core), .core_state(core_state), .core_hold(core_hold),
    .force_call(force_call), .call_vector(call_vector),
    .restore_valid(restore_valid), .restore_frame(restore_frame),
    .global_en(global_en), .usb_clear_regs(usb_clear_regs),
    .abort_por_delay(abort_por_delay)
  );
  uhic_core_model core_model (
    .pclk(pclk), .presetn(presetn), .req(creq), .core_hold(core_hold),
    .force_call(force_call), .call_vector(call_vector),
    .restore_valid(restore_valid), .restore_frame(restore_frame),
    .core(core), .core_state(core_state)
  );
  // Clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // Frame the core offers at each completion while global_en is set, and pulse counters
  always @(posedge pclk) begin
    if (core.instr_done === 1'b1 && global_en === 1'b1) snap <= core_state;
    if (force_call === 1'b1) calls <= calls + 1;
    if (usb_clear_regs === 1'b1) clears <= clears + 1;
    if (abort_por_delay === 1'b1) aborts <= aborts + 1;
  end
  task automatic chk(input logic [31:0] got, exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; waits for pready, only the watchdog bounds it
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, $sformatf("reg %h", a));
  endtask
  task automatic pulse(input logic [29:0] m);
    @(posedge pclk);
    evt <= m;
    @(posedge pclk);
    evt <= 30'h0;
  endtask
  task automatic core_req(input logic [2:0] m);
    @(posedge pclk);
    creq <= m;
    @(posedge pclk);
    creq <= 3'h0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Waits for one acknowledge, checks it, then returns from the handler
  task automatic serve(input int src);
    int n;
    n = 0;
    while (global_en !== 1'b1 && n < 99) begin @(posedge pclk); n++; end
    n = 0;
    while (global_en !== 1'b0 && n < 99) begin @(posedge pclk); n++; end
    n = 0;
    while (force_call !== 1'b1 && n < 99) begin @(posedge pclk); n++; end
    chk(n, UHIC_CALL_CYC, "call latency");
    chk({31'h0, global_en}, 32'h0, "gie at call");
    chk({18'h0, call_vector}, {18'h0, UHIC_VEC_BASE + 14'(2 * src)},
        "vector");
    exp_pend[src] = 1'b0;
    rd(UHIC_A_PENDING, {20'h0, exp_pend});
    core_req(3'b001);
    n = 0;
    while (restore_valid !== 1'b1 && n < 99) begin @(posedge pclk); n++; end
    chk({16'h0, restore_frame}, {16'h0, snap}, "frame");
    chk({31'h0, global_en}, 32'h1, "gie after return");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    idle(20000);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
  // Test sequence
  initial begin
    logic [31:0] q;
    logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata, evt, creq} = '0;
    {up_dp, up_dm, ep_in_nak, gpio_trig, exp_pend} = {2'b10, 25'h0};
    hub_port_en = 7'h04;
    hub_forced = 7'h01;
    idle(8);
    presetn <= 1'b1;
    rd(UHIC_A_GLOBAL_EN, 32'h0);
    rd(UHIC_A_EP_EN, 32'h0);
    rd(UHIC_A_STATUS, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    $display("test reset done");
    pulse(30'h1);
    pulse(30'h1);
    pulse(30'h2);
    pulse(30'h44);
    ep_in_nak <= 5'h02;
    pulse(30'h8);
    ep_in_nak <= 5'h00;
    pulse(30'h20200);
    exp_pend = 12'h08e;
    rd(UHIC_A_PENDING, {20'h0, exp_pend});
    rd(UHIC_A_STATUS, 32'h0);
    wr(UHIC_A_GPIO_PEN, 32'h3);
    pulse(30'h180);
    pulse(30'h2000000);
    gpio_trig[0] <= 1'b1;
    idle(4);
    exp_pend = 12'hf8e;
    rd(UHIC_A_PENDING, {20'h0, exp_pend});
    wr(UHIC_A_GLOBAL_EN, 32'hff);
    wr(UHIC_A_EP_EN, 32'hff);
    rd(UHIC_A_GLOBAL_EN, 32'h6f);
    rd(UHIC_A_EP_EN, 32'h1f);
    idle(30);
    chk(calls, 0, "call while disabled");
    rd(UHIC_A_STATUS, 32'h80);
    $display("test pending done");
    core_req(3'b100);
    foreach (order[i]) serve(order[i]);
    gpio_trig[1] <= 1'b1;
    idle(10);
    rd(UHIC_A_PENDING, 32'h0);
    rd(UHIC_A_GPIO_PEN, 32'h3);
    chk(calls, 8, "call count");
    gpio_trig <= 8'h00;
    $display("test service done");
    core_req(3'b010);
    idle(12);
    chk({31'h0, global_en}, 32'h0, "gie after disable");
    {up_dp, up_dm} <= 2'b00;
    idle(SE0_SMALL + 10);
    rd(UHIC_A_STATUS, 32'h20);
    rd(UHIC_A_PENDING, 32'h0);
    chk(clears, 1, "register clear");
    chk(aborts, 1, "delay abort");
    up_dp <= 1'b1;
    idle(10);
    exp_pend = 12'h001;
    rd(UHIC_A_PENDING, 32'h1);
    rd(UHIC_A_STATUS, 32'ha0);
    wr(UHIC_A_STATUS, 32'h20);
    rd(UHIC_A_STATUS, 32'h80);
    core_req(3'b100);
    serve(UHIC_S_BUSRST);
    $display("test bus reset done");
    pulse(30'h1);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    chk({31'h0, global_en}, 32'h0, "gie after reset");
    rd(UHIC_A_GLOBAL_EN, 32'h0);
    rd(UHIC_A_EP_EN, 32'h0);
    rd(UHIC_A_PENDING, 32'h0);
    $display("test second reset done");
    wrap_up();
  end
endmodule
